// ==== include/auto_reload_timer16_defines.vh ====
// Register map, field positions and reset values of the auto-reload timer
`ifndef AUTO_RELOAD_TIMER16_DEFINES_VH
`define AUTO_RELOAD_TIMER16_DEFINES_VH

// ==========================================================
// Register offsets
`define ADDR_W 8
`define DATA_W 8
`define ADDR_TIMER_CONTROL 8'hc4
`define ADDR_RELOAD_LOW 8'hc5
`define ADDR_RELOAD_HIGH 8'hc6
`define ADDR_IRQ_STATUS 8'hc7
`define ADDR_IRQ_MASK 8'hc8
`define ADDR_COUNT_LOW 8'hc9
`define ADDR_COUNT_HIGH 8'hca

// ==========================================================
// Control register fields
`define PRESCALE_LSB 0
`define PRESCALE_MSB 2
`define RUN_BIT 3
`define OVERFLOW_BIT 4
`define BAUD_SOURCE_BIT 5
`define FRAME_ERR_SEL_BIT 6
`define DOUBLE_RATE_BIT 7

// ==========================================================
// Event status and mask fields
`define EVT_W 2
`define EVT_OVERFLOW 0
`define EVT_RELOAD_WHILE_RUN 1

// ==========================================================
// Widths and reset values
`define COUNT_W 16
`define PRESCALE_W 3
`define DIV_W 7
`define COUNT_MAX 16'hffff
`define COUNT_ONE 16'h0001
`define CONTROL_RESET 8'h00
`define PRESCALE_RESET 3'h0
`define RELOAD_RESET 8'h00
`define COUNT_RESET 16'h0000
`define EVT_RESET 2'h0
`define READ_ZERO 8'h00
`define DIV_ONE 7'h01
`define DIV_ZERO 7'h00

`endif

// ==== sim/tb_auto_reload_timer16.sv ====
// Self-checking bench of the auto-reload timer
`timescale 1ns/1ps
module tb_auto_reload_timer16;
   logic clk = 0, rst_n = 1, wr_stb = 0, rd_stb = 0, irq_en = 0, isr = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, w, lo;
   logic irq, req, baud, dbl, fes, bsrc;
   int errors = 0, samples_checked = 0, n;
   integer seed = 32'he9166a28;
   auto_reload_timer16 DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .timer_irq_enable(irq_en), .isr_enter(isr), .timer_irq_req(req),
      .irq(irq), .baud_tick(baud), .serial_b_double_rate(dbl), .serial_b_frame_error_select(fes),
      .serial_b_baud_source(bsrc));
   initial forever #12.5 clk = ~clk;
   // ==========================================
   // Tasks
   task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task cmpn(input string nm, input int e, input int g);
      samples_checked++;
      if (g != e) begin
         errors++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, g);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task rd(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   // Bound covers a full 16-bit count from zero at 1/1
   task wait_baud;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (baud !== 1'b1 && n < 70000);
      if (n >= 70000) begin
         errors++;
         report_and_stop;
      end
   endtask
   task report_and_stop;
      $display("compares %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // Sequence
   initial begin
      // A real falling edge, so the asynchronous reset acts before the first clock edge
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(i < 7 ? 8'hc4 + 8'(i) : 8'hd0);
         cmp("reset read", 8'h00, v);
      end
      cmp("reset pins", 8'h00, {2'b00, irq, req, baud, dbl, fes, bsrc});
      $display("test reset done");
      irq_en <= 1'b1;
      wr(8'hc4, 8'hf0);
      #1 cmp("serial", 8'h07, {5'h00, dbl, fes, bsrc});
      cmp("sw set", 8'h01, {7'h00, req});
      irq_en <= 1'b0;
      @(posedge clk);
      #1 cmp("req gated", 8'h00, {7'h00, req});
      irq_en <= 1'b1;
      @(posedge clk);
      isr <= 1'b1;
      @(posedge clk);
      isr <= 1'b0;
      rd(8'hc4);
      cmp("isr clear", 8'he0, v);
      wr(8'hc4, 8'h10);
      wr(8'hc4, 8'h00);
      rd(8'hc4);
      cmp("sw clear", 8'h00, v);
      $display("test flag done");
      lo = 8'hf0 | 8'($random(seed) & 7);
      wr(8'hc5, lo);
      wr(8'hc6, 8'hff);
      wr(8'hc4, 8'h08);
      wait_baud;
      rd(8'hc4);
      cmp("overflow", 8'h18, v);
      wr(8'hc4, 8'h00);
      rd(8'hc9);
      w = v;
      repeat (10) @(posedge clk);
      rd(8'hc9);
      cmp("count held", w, v);
      cmp("count reloaded", 8'h01, {7'h00, v >= lo});
      rd(8'hca);
      cmp("high byte", 8'hff, v);
      rd(8'hc7);
      cmp("status", 8'h01, v);
      wr(8'hc8, 8'h01);
      #1 cmp("irq on", 8'h01, {7'h00, irq});
      wr(8'hc8, 8'h00);
      #1 cmp("irq masked", 8'h00, {7'h00, irq});
      wr(8'hc8, 8'h01);
      wr(8'hc7, 8'h01);
      #1 cmp("irq cleared", 8'h00, {7'h00, irq});
      $display("test rollover done");
      for (int p = 0; p < 8; p++) begin
         lo = 8'hf0 | 8'($random(seed) & 7);
         wr(8'hc4, 8'h00);
         wr(8'hc5, lo);
         wr(8'hc4, 8'h08 | 8'(p));
         wait_baud;
         wait_baud;
         cmpn("period", (256 - lo) << p, n);
      end
      $display("test prescale done");
      // Deliberate misuse while running: only the event flag is defined, not the count
      lo = 8'hf0 | 8'($random(seed) & 7);
      wr(8'hc5, lo);
      rd(8'hc7);
      cmp("misuse flag", 8'h03, v);
      wr(8'hc8, 8'h02);
      #1 cmp("misuse irq", 8'h01, {7'h00, irq});
      $display("test misuse done");
      report_and_stop;
   end
endmodule
bind auto_reload_timer16 timer_checker chk (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .timer_irq_enable(timer_irq_enable),
   .isr_enter(isr_enter), .timer_irq_req(timer_irq_req), .irq(irq), .baud_tick(baud_tick),
   .serial_b_double_rate(serial_b_double_rate), .serial_b_frame_error_select(serial_b_frame_error_select),
   .serial_b_baud_source(serial_b_baud_source));

// ==== sim/timer_checker_assertions.sv ====
// Port-level assertions of the auto-reload timer
`timescale 1ns/1ps
module timer_checker (
   input logic clk,
   input logic rst_n,
   input logic [7:0] addr,
   input logic [7:0] wdata,
   input logic wr_stb,
   input logic rd_stb,
   input logic [7:0] rdata,
   input logic timer_irq_enable,
   input logic isr_enter,
   input logic timer_irq_req,
   input logic irq,
   input logic baud_tick,
   input logic serial_b_double_rate,
   input logic serial_b_frame_error_select,
   input logic serial_b_baud_source
);
   logic ctl_hit;
   assign ctl_hit = wr_stb && addr == 8'hc4;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Steps
   // Six quiet cycles leave room for a rollover caught at the halting edge
   sequence halt_idle;
      ctl_hit && !wdata[3] ##1 !wr_stb [*6];
   endsequence
   sequence flag_write;
      ctl_hit && wdata[4] ##1 timer_irq_enable;
   endsequence
   // ==========================================
   // Checks
   req_gate_a: assert property (timer_irq_req |-> timer_irq_enable)
      else $error("request without enable");
   isr_clear_a: assert property (isr_enter && !ctl_hit |=> (!timer_irq_req || baud_tick) or ##1 baud_tick)
      else $error("flag survived service entry");
   sw_set_a: assert property (flag_write |-> timer_irq_req)
      else $error("software set of flag lost");
   flag_cause_a: assert property ($rose(timer_irq_req) && $past(timer_irq_enable)
      |-> $past(ctl_hit) or baud_tick or ##1 baud_tick)
      else $error("flag rose without cause");
   halt_quiet_a: assert property (halt_idle |=> !baud_tick)
      else $error("rollover while halted");
   serial_bits_a: assert property (ctl_hit |=> {serial_b_double_rate, serial_b_frame_error_select,
      serial_b_baud_source} == $past(wdata[7:5]))
      else $error("serial selects wrong");
   idle_rdata_a: assert property (!$past(rd_stb) |-> rdata == 8'h00)
      else $error("read data outside read slot");
   reset_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !irq && !timer_irq_req && !baud_tick
      && rdata == 8'h00)
      else $error("outputs active in reset");
endmodule

// ==== verilog/auto_reload_timer16.v ====
// Sixteen-bit up-counting auto-reload timer with prescaler and register port
// Function
// - One 16-bit counter, up-counting with automatic reload, no other modes.
// - Three-bit prescale selects count clock divide of 1 to 128 by powers of two.
// - Counter advances only while run bit (control bit 3) is one.
// - Rollover past ffff sets overflow flag and loads reload bytes into counter.
// - Interrupt request while overflow flag and timer interrupt enable are both set.
// - Overflow flag clears in hardware on entry to its service routine.
// - Software may also set or clear overflow flag at control bit 4.
// - Reload value is high byte and low byte register side by side.
// - Overflow serves as baud clock source selectable by either serial port.
// - Control and both reload registers reset to zero: halted, 1/1, reload zero.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "auto_reload_timer16_defines.vh"

module auto_reload_timer16 (
   clk,
   rst_n,
   addr,
   wdata,
   wr_stb,
   rd_stb,
   rdata,
   timer_irq_enable,
   isr_enter,
   timer_irq_req,
   irq,
   baud_tick,
   serial_b_double_rate,
   serial_b_frame_error_select,
   serial_b_baud_source
);
   input wire clk;
   input wire rst_n;
   input wire [`ADDR_W-1:0] addr;
   input wire [`DATA_W-1:0] wdata;
   input wire wr_stb;
   input wire rd_stb;
   output reg [`DATA_W-1:0] rdata;
   input wire timer_irq_enable;
   input wire isr_enter;
   output wire timer_irq_req;
   output wire irq;
   output reg baud_tick;
   output wire serial_b_double_rate;
   output wire serial_b_frame_error_select;
   output wire serial_b_baud_source;

   // ==========================================================
   // Storage
   reg [`PRESCALE_W-1:0] prescale_select_q;
   reg run_bit_q;
   reg overflow_flag_q;
   reg overflow_flag_d;
   reg serial_b_baud_source_q;
   reg serial_b_frame_error_select_q;
   reg serial_b_double_rate_q;
   reg [`DATA_W-1:0] reload_low_q;
   reg [`DATA_W-1:0] reload_high_q;
   reg [`COUNT_W-1:0] count_q;
   reg [`COUNT_W-1:0] count_d;
   reg [`EVT_W-1:0] evt_status_q;
   reg [`EVT_W-1:0] evt_status_d;
   reg [`EVT_W-1:0] evt_mask_q;
   reg [`DATA_W-1:0] rdata_d;

   // ==========================================================
   // Decode
   wire wr_control;
   wire wr_reload_low;
   wire wr_reload_high;
   wire wr_status;
   wire wr_mask;
   wire count_tick;
   wire rollover;
   wire [`COUNT_W-1:0] reload_value;
   wire [`DATA_W-1:0] control_view;
   wire [`EVT_W-1:0] evt_set;

   assign wr_control = wr_stb & (addr == `ADDR_TIMER_CONTROL);
   assign wr_reload_low = wr_stb & (addr == `ADDR_RELOAD_LOW);
   assign wr_reload_high = wr_stb & (addr == `ADDR_RELOAD_HIGH);
   assign wr_status = wr_stb & (addr == `ADDR_IRQ_STATUS);
   assign wr_mask = wr_stb & (addr == `ADDR_IRQ_MASK);

   // ==========================================================
   // Prescaler
   // Clocked from the system clock, gated by the run bit
   prescale_divider u_prescale (
      .clk(clk),
      .rst_n(rst_n),
      .enable(run_bit_q),
      .select(prescale_select_q),
      .tick(count_tick)
   );

   // ==========================================================
   // Counter
   assign reload_value = {reload_high_q, reload_low_q};
   assign rollover = count_tick & (count_q == `COUNT_MAX);

   always @* begin
      count_d = count_q;
      if (rollover) begin
         count_d = reload_value;
      end else if (count_tick) begin
         count_d = count_q + `COUNT_ONE;
      end
   end

   // Halted counter holds its value and resumes from it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= `COUNT_RESET;
      end else if (run_bit_q) begin
         count_q <= count_d;
      end
   end

   // ==========================================================
   // Overflow flag
   // A rollover in the same cycle as a clear keeps the flag set
   always @* begin
      overflow_flag_d = overflow_flag_q;
      if (wr_control) begin
         overflow_flag_d = wdata[`OVERFLOW_BIT];
      end else if (isr_enter) begin
         overflow_flag_d = 1'b0;
      end
      if (rollover) begin
         overflow_flag_d = 1'b1;
      end
   end

   // ==========================================================
   // Control and reload registers
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prescale_select_q <= `PRESCALE_RESET;
         run_bit_q <= 1'b0;
         overflow_flag_q <= 1'b0;
         serial_b_baud_source_q <= 1'b0;
         serial_b_frame_error_select_q <= 1'b0;
         serial_b_double_rate_q <= 1'b0;
         reload_low_q <= `RELOAD_RESET;
         reload_high_q <= `RELOAD_RESET;
      end else begin
         overflow_flag_q <= overflow_flag_d;
         if (wr_control) begin
            prescale_select_q <= wdata[`PRESCALE_MSB:`PRESCALE_LSB];
            run_bit_q <= wdata[`RUN_BIT];
            serial_b_baud_source_q <= wdata[`BAUD_SOURCE_BIT];
            serial_b_frame_error_select_q <= wdata[`FRAME_ERR_SEL_BIT];
            serial_b_double_rate_q <= wdata[`DOUBLE_RATE_BIT];
         end
         // Taken even while running; the count then in flight is undefined
         if (wr_reload_low) begin
            reload_low_q <= wdata;
         end
         if (wr_reload_high) begin
            reload_high_q <= wdata;
         end
      end
   end

   // ==========================================================
   // Baud clock source
   // One system-clock pulse per rollover, shared by both serial ports
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= rollover;
      end
   end

   assign serial_b_baud_source = serial_b_baud_source_q;
   assign serial_b_frame_error_select = serial_b_frame_error_select_q;
   assign serial_b_double_rate = serial_b_double_rate_q;

   // ==========================================================
   // Interrupts
   // Reload writes while running are flagged so software can spot the misuse
   assign evt_set[`EVT_OVERFLOW] = rollover;
   assign evt_set[`EVT_RELOAD_WHILE_RUN] = (wr_reload_low | wr_reload_high) & run_bit_q;

   // Write one to clear; a new event in the clearing cycle wins
   always @* begin
      evt_status_d = evt_status_q;
      if (wr_status) begin
         evt_status_d = evt_status_q & ~wdata[`EVT_W-1:0];
      end
      evt_status_d = evt_status_d | evt_set;
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         evt_status_q <= `EVT_RESET;
         evt_mask_q <= `EVT_RESET;
      end else begin
         evt_status_q <= evt_status_d;
         if (wr_mask) begin
            evt_mask_q <= wdata[`EVT_W-1:0];
         end
      end
   end

   assign timer_irq_req = overflow_flag_q & timer_irq_enable;
   assign irq = |(evt_status_q & evt_mask_q);

   // ==========================================================
   // Read port
   assign control_view = {serial_b_double_rate_q, serial_b_frame_error_select_q,
                          serial_b_baud_source_q, overflow_flag_q, run_bit_q,
                          prescale_select_q};

   always @* begin
      case (addr)
         `ADDR_TIMER_CONTROL: begin
            rdata_d = control_view;
         end
         `ADDR_RELOAD_LOW: begin
            rdata_d = reload_low_q;
         end
         `ADDR_RELOAD_HIGH: begin
            rdata_d = reload_high_q;
         end
         `ADDR_IRQ_STATUS: begin
            rdata_d = {{(`DATA_W-`EVT_W){1'b0}}, evt_status_q};
         end
         `ADDR_IRQ_MASK: begin
            rdata_d = {{(`DATA_W-`EVT_W){1'b0}}, evt_mask_q};
         end
         `ADDR_COUNT_LOW: begin
            rdata_d = count_q[`DATA_W-1:0];
         end
         `ADDR_COUNT_HIGH: begin
            rdata_d = count_q[`COUNT_W-1:`DATA_W];
         end
         default: begin
            rdata_d = `READ_ZERO;
         end
      endcase
   end

   // Data stand only in the cycle after the read strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= `READ_ZERO;
      end else if (rd_stb) begin
         rdata <= rdata_d;
      end else begin
         rdata <= `READ_ZERO;
      end
   end
endmodule

// ==== verilog/prescale_divider.v ====
// Power-of-two clock prescaler giving a one-cycle count enable
`timescale 1ns/1ps
`include "auto_reload_timer16_defines.vh"

module prescale_divider (
   clk,
   rst_n,
   enable,
   select,
   tick
);
   input wire clk;
   input wire rst_n;
   input wire enable;
   input wire [`PRESCALE_W-1:0] select;
   output wire tick;

   // ==========================================================
   // Divider chain
   reg [`DIV_W-1:0] div_q;
   reg [`DIV_W-1:0] div_d;
   reg [`DIV_W-1:0] low_mask;

   always @* begin
      low_mask = (`DIV_ONE << select) - `DIV_ONE;
      // Cleared while halted so each run starts a full prescale period
      if (enable) begin
         div_d = div_q + `DIV_ONE;
      end else begin
         div_d = `DIV_ZERO;
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_q <= `DIV_ZERO;
      end else begin
         div_q <= div_d;
      end
   end

   // Select 0 has an empty mask and ticks every cycle
   assign tick = enable & ((div_q & low_mask) == low_mask);
endmodule
